//--- rtl/dcc_cfg.svh
// address map, field positions and reset values of the comparator control registers
`ifndef DCC_CFG_SVH
`define DCC_CFG_SVH
`define DCC_ADDR_CMP1_CTRL   8'h9A
`define DCC_ADDR_CMP1_MODE   8'h9C
`define DCC_ADDR_CMP0_MODE   8'h9D
`define DCC_ADDR_CMP1_INSEL  8'h9E
`define DCC_ADDR_CMP0_INSEL  8'h9F
`define DCC_RST_CTRL         8'h00
`define DCC_RST_MODE         8'h02
`define DCC_RST_INSEL        8'hFF
`define DCC_MASK_INSEL       8'h33
`define DCC_MASK_MODE        8'h33
`define DCC_MASK_CTRL_RW     8'h8F
`define DCC_FILL_INSEL       8'hCC
`define DCC_BIT_EN           7
`define DCC_BIT_OUT          6
`define DCC_BIT_RISE         5
`define DCC_BIT_FALL         4
`define DCC_SYNC_STAGES      2
`endif

//--- rtl/dcc_pkg.sv
// types shared by the comparator control register block
package dcc_pkg;
    typedef struct packed {
        logic [1:0] neg_sel;
        logic [1:0] pos_sel;
    } dcc_insel_t;
    typedef struct packed {
        logic       rise_irq_en;
        logic       fall_irq_en;
        logic [1:0] speed_mode;
    } dcc_mode_t;
    typedef struct packed {
        logic       enable;
        logic [1:0] pos_hyst;
        logic [1:0] neg_hyst;
    } dcc_ctrl_t;
    typedef enum logic [1:0] {
        DCC_SPEED_M0 = 2'h0,
        DCC_SPEED_M1 = 2'h1,
        DCC_SPEED_M2 = 2'h2,
        DCC_SPEED_M3 = 2'h3
    } dcc_speed_t;
endpackage

//--- rtl/dcc_regs.sv
// comparator control registers, edge flags and interrupt requests
`timescale 1ns/100ps
`include "dcc_cfg.svh"
module dcc_regs #(
    parameter int SYNC_STAGES = `DCC_SYNC_STAGES
) (
    // clock and reset
    input  wire logic              clock_i,
    input  wire logic              rst_i,
    // special-function register port
    input  wire logic [7:0]        sfr_addr_i,
    input  wire logic [7:0]        sfr_wdata_i,
    input  wire logic              sfr_we_i,
    output logic      [7:0]        sfr_rdata_o,
    // comparator cores
    input  wire logic              cmp1_raw_i,
    input  wire logic              cmp0_rise_flag_i,
    input  wire logic              cmp0_fall_flag_i,
    output dcc_pkg::dcc_insel_t    cmp0_insel_o,
    output dcc_pkg::dcc_insel_t    cmp1_insel_o,
    output dcc_pkg::dcc_mode_t     cmp0_mode_o,
    output dcc_pkg::dcc_mode_t     cmp1_mode_o,
    output dcc_pkg::dcc_ctrl_t     cmp1_ctrl_o,
    // interrupt requests
    output logic                   cmp0_irq_o,
    output logic                   cmp1_irq_o
);
    initial
    begin
        if (SYNC_STAGES < 2)
            $error("SYNC_STAGES must be at least 2");
    end

    dcc_pkg::dcc_insel_t      insel0_q;
    dcc_pkg::dcc_insel_t      insel1_q;
    dcc_pkg::dcc_mode_t       mode0_q;
    dcc_pkg::dcc_mode_t       mode1_q;
    dcc_pkg::dcc_ctrl_t       ctrl1_q;
    logic                     rise_q;
    logic                     fall_q;
    logic [SYNC_STAGES-1:0]   sync_q;
    logic                     out_q;
    logic                     out_d;
    logic                     rise_ev;
    logic                     fall_ev;
    logic                     wr_ctrl;
    // per-register write strobes and a map hit, shared by the checks below
    logic                     wr_insel0;
    logic                     wr_insel1;
    logic                     wr_mode0;
    logic                     wr_mode1;
    logic                     addr_hit;

    // address decode is page independent
    assign wr_ctrl   = sfr_we_i && (sfr_addr_i == `DCC_ADDR_CMP1_CTRL);
    assign wr_insel0 = sfr_we_i && (sfr_addr_i == `DCC_ADDR_CMP0_INSEL);
    assign wr_insel1 = sfr_we_i && (sfr_addr_i == `DCC_ADDR_CMP1_INSEL);
    assign wr_mode0  = sfr_we_i && (sfr_addr_i == `DCC_ADDR_CMP0_MODE);
    assign wr_mode1  = sfr_we_i && (sfr_addr_i == `DCC_ADDR_CMP1_MODE);
    assign addr_hit  = (sfr_addr_i == `DCC_ADDR_CMP1_CTRL)
                    || (sfr_addr_i == `DCC_ADDR_CMP1_MODE)
                    || (sfr_addr_i == `DCC_ADDR_CMP0_MODE)
                    || (sfr_addr_i == `DCC_ADDR_CMP1_INSEL)
                    || (sfr_addr_i == `DCC_ADDR_CMP0_INSEL);

    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            insel0_q <= dcc_pkg::dcc_insel_t'(4'hF);
            insel1_q <= dcc_pkg::dcc_insel_t'(4'hF);
        end
        else if (sfr_we_i)
        begin
            // only select fields store, unused bits dropped
            if (sfr_addr_i == `DCC_ADDR_CMP0_INSEL)
                insel0_q <= {sfr_wdata_i[5:4], sfr_wdata_i[1:0]};
            if (sfr_addr_i == `DCC_ADDR_CMP1_INSEL)
                insel1_q <= {sfr_wdata_i[5:4], sfr_wdata_i[1:0]};
        end
    end

    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            mode0_q <= dcc_pkg::dcc_mode_t'(4'h2);
            mode1_q <= dcc_pkg::dcc_mode_t'(4'h2);
        end
        else if (sfr_we_i)
        begin
            // enables and speed field only
            if (sfr_addr_i == `DCC_ADDR_CMP0_MODE)
                mode0_q <= {sfr_wdata_i[5:4], sfr_wdata_i[1:0]};
            if (sfr_addr_i == `DCC_ADDR_CMP1_MODE)
                mode1_q <= {sfr_wdata_i[5:4], sfr_wdata_i[1:0]};
        end
    end

    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
            ctrl1_q <= '0;
        else if (wr_ctrl)
            // hysteresis codes pass straight to the core
            ctrl1_q <= {sfr_wdata_i[`DCC_BIT_EN], sfr_wdata_i[3:0]};
    end

    // raw output is asynchronous; a disabled core reads low
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
            sync_q <= '0;
        else
            sync_q <= {sync_q[SYNC_STAGES-2:0], cmp1_raw_i & ctrl1_q.enable};
    end

    assign out_d = sync_q[SYNC_STAGES-1];

    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
            out_q <= 1'b0;
        else
            out_q <= out_d;
    end

    assign rise_ev = out_d & ~out_q;
    assign fall_ev = ~out_d & out_q;

    // a new edge wins over a software clear in the same cycle
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            rise_q <= 1'b0;
            fall_q <= 1'b0;
        end
        else
        begin
            if (rise_ev)
                rise_q <= 1'b1;
            else if (wr_ctrl)
                rise_q <= sfr_wdata_i[`DCC_BIT_RISE];
            if (fall_ev)
                fall_q <= 1'b1;
            else if (wr_ctrl)
                fall_q <= sfr_wdata_i[`DCC_BIT_FALL];
        end
    end

    always_comb
    begin
        case (sfr_addr_i)
            `DCC_ADDR_CMP0_INSEL:
                sfr_rdata_o = `DCC_FILL_INSEL | {2'h0, insel0_q[3:2], 2'h0, insel0_q[1:0]};
            `DCC_ADDR_CMP1_INSEL:
                sfr_rdata_o = `DCC_FILL_INSEL | {2'h0, insel1_q[3:2], 2'h0, insel1_q[1:0]};
            `DCC_ADDR_CMP0_MODE:
                sfr_rdata_o = {2'h0, mode0_q[3:2], 2'h0, mode0_q[1:0]};
            `DCC_ADDR_CMP1_MODE:
                sfr_rdata_o = {2'h0, mode1_q[3:2], 2'h0, mode1_q[1:0]};
            `DCC_ADDR_CMP1_CTRL:
                sfr_rdata_o = {ctrl1_q.enable, out_q, rise_q, fall_q, ctrl1_q[3:0]};
            default:
                sfr_rdata_o = 8'h00;
        endcase
    end

    assign cmp0_insel_o = insel0_q;
    assign cmp1_insel_o = insel1_q;
    assign cmp0_mode_o  = mode0_q;
    assign cmp1_mode_o  = mode1_q;
    assign cmp1_ctrl_o  = ctrl1_q;

    // flags stay set until software clears them after retuning
    assign cmp1_irq_o = (rise_q & mode1_q.rise_irq_en) | (fall_q & mode1_q.fall_irq_en);
    assign cmp0_irq_o = (cmp0_rise_flag_i & mode0_q.rise_irq_en)
                      | (cmp0_fall_flag_i & mode0_q.fall_irq_en);

    sequence rise_seen_s;
        !out_q ##1 out_q;
    endsequence

    sequence fall_seen_s;
        out_q ##1 !out_q;
    endsequence

    // a clear only counts when no new edge arrives in the same cycle
    sequence rise_clear_s;
        wr_ctrl && !sfr_wdata_i[`DCC_BIT_RISE] && !rise_ev;
    endsequence

    sequence fall_clear_s;
        wr_ctrl && !sfr_wdata_i[`DCC_BIT_FALL] && !fall_ev;
    endsequence

    insel_rsv_a: assert property (@(posedge clock_i) disable iff (rst_i)
        (sfr_addr_i == `DCC_ADDR_CMP0_INSEL) |-> (sfr_rdata_o & `DCC_FILL_INSEL) == `DCC_FILL_INSEL)
        else $error("input select unused bits not one");
    mode_rsv_a: assert property (@(posedge clock_i) disable iff (rst_i)
        (sfr_addr_i == `DCC_ADDR_CMP1_MODE) |-> (sfr_rdata_o & ~`DCC_MASK_MODE) == 8'h00)
        else $error("mode unused bits not zero");
    mode_write_a: assert property (@(posedge clock_i) disable iff (rst_i)
        (sfr_we_i && sfr_addr_i == `DCC_ADDR_CMP1_MODE) |=>
        mode1_q.rise_irq_en == $past(sfr_wdata_i[5]) && mode1_q.speed_mode == $past(sfr_wdata_i[1:0]))
        else $error("mode write not stored");
    rise_flag_a: assert property (@(posedge clock_i) disable iff (rst_i)
        rise_seen_s |-> rise_q)
        else $error("rising edge not flagged");
    fall_flag_a: assert property (@(posedge clock_i) disable iff (rst_i)
        $fell(out_q) |-> fall_q)
        else $error("falling edge not flagged");
    flag_hold_a: assert property (@(posedge clock_i) disable iff (rst_i)
        (rise_q && !wr_ctrl) |=> rise_q)
        else $error("rise flag dropped without clear");
    dis_low_a: assert property (@(posedge clock_i) disable iff (rst_i)
        (!ctrl1_q.enable)[*4] |-> !out_q)
        else $error("disabled output not low");
    irq_req_a: assert property (@(posedge clock_i) disable iff (rst_i)
        (fall_q && mode1_q.fall_irq_en) |-> cmp1_irq_o)
        else $error("interrupt request missing");
    out_read_a: assert property (@(posedge clock_i) disable iff (rst_i)
        (sfr_addr_i == `DCC_ADDR_CMP1_CTRL) |-> sfr_rdata_o[`DCC_BIT_OUT] == out_q)
        else $error("output state bit wrong");

    // read-back of unused bits and the map
    insel1_rsv_a: assert property (@(posedge clock_i) disable iff (rst_i)
        (sfr_addr_i == `DCC_ADDR_CMP1_INSEL) |-> (sfr_rdata_o & `DCC_FILL_INSEL) == `DCC_FILL_INSEL)
        else $error("input select 1 unused bits not one");
    mode0_rsv_a: assert property (@(posedge clock_i) disable iff (rst_i)
        (sfr_addr_i == `DCC_ADDR_CMP0_MODE) |-> (sfr_rdata_o & ~`DCC_MASK_MODE) == 8'h00)
        else $error("mode 0 unused bits not zero");
    unmapped_rd_a: assert property (@(posedge clock_i) disable iff (rst_i)
        !addr_hit |-> sfr_rdata_o == 8'h00)
        else $error("unmapped address read not zero");

    // input select fields
    insel0_write_a: assert property (@(posedge clock_i) disable iff (rst_i)
        wr_insel0 |=> insel0_q.neg_sel == $past(sfr_wdata_i[5:4]))
        else $error("input select 0 negative field not stored");
    insel0_pos_a: assert property (@(posedge clock_i) disable iff (rst_i)
        wr_insel0 |=> insel0_q.pos_sel == $past(sfr_wdata_i[1:0]))
        else $error("input select 0 positive field not stored");
    insel1_write_a: assert property (@(posedge clock_i) disable iff (rst_i)
        wr_insel1 |=> insel1_q == $past({sfr_wdata_i[5:4], sfr_wdata_i[1:0]}))
        else $error("input select 1 not stored");
    insel1_read_a: assert property (@(posedge clock_i) disable iff (rst_i)
        (sfr_addr_i == `DCC_ADDR_CMP1_INSEL) |-> sfr_rdata_o[5:4] == insel1_q.neg_sel)
        else $error("input select 1 read wrong");
    insel0_hold_a: assert property (@(posedge clock_i) disable iff (rst_i)
        !wr_insel0 |=> $stable(insel0_q))
        else $error("input select 0 changed without write");
    insel1_hold_a: assert property (@(posedge clock_i) disable iff (rst_i)
        !wr_insel1 |=> $stable(insel1_q))
        else $error("input select 1 changed without write");

    // mode fields
    mode0_write_a: assert property (@(posedge clock_i) disable iff (rst_i)
        wr_mode0 |=> mode0_q.fall_irq_en == $past(sfr_wdata_i[4]))
        else $error("mode 0 fall enable not stored");
    mode1_fall_a: assert property (@(posedge clock_i) disable iff (rst_i)
        wr_mode1 |=> mode1_q.fall_irq_en == $past(sfr_wdata_i[4]))
        else $error("mode 1 fall enable not stored");
    mode0_speed_a: assert property (@(posedge clock_i) disable iff (rst_i)
        wr_mode0 |=> mode0_q.speed_mode == $past(sfr_wdata_i[1:0]))
        else $error("mode 0 speed not stored");
    mode0_hold_a: assert property (@(posedge clock_i) disable iff (rst_i)
        !wr_mode0 |=> $stable(mode0_q))
        else $error("mode 0 changed without write");
    mode1_hold_a: assert property (@(posedge clock_i) disable iff (rst_i)
        !wr_mode1 |=> $stable(mode1_q))
        else $error("mode 1 changed without write");
    mode1_read_a: assert property (@(posedge clock_i) disable iff (rst_i)
        (sfr_addr_i == `DCC_ADDR_CMP1_MODE) |-> sfr_rdata_o[5] == mode1_q.rise_irq_en)
        else $error("mode 1 rise enable read wrong");
    mode0_read_a: assert property (@(posedge clock_i) disable iff (rst_i)
        (sfr_addr_i == `DCC_ADDR_CMP0_MODE) |-> sfr_rdata_o[4] == mode0_q.fall_irq_en)
        else $error("mode 0 fall enable read wrong");

    // control fields
    ctrl_write_a: assert property (@(posedge clock_i) disable iff (rst_i)
        wr_ctrl |=> ctrl1_q.enable == $past(sfr_wdata_i[`DCC_BIT_EN]))
        else $error("enable not stored");
    pos_hyst_a: assert property (@(posedge clock_i) disable iff (rst_i)
        wr_ctrl |=> ctrl1_q.pos_hyst == $past(sfr_wdata_i[3:2]))
        else $error("positive hysteresis not stored");
    neg_hyst_a: assert property (@(posedge clock_i) disable iff (rst_i)
        wr_ctrl |=> ctrl1_q.neg_hyst == $past(sfr_wdata_i[1:0]))
        else $error("negative hysteresis not stored");
    ctrl_hold_a: assert property (@(posedge clock_i) disable iff (rst_i)
        !wr_ctrl |=> $stable(ctrl1_q))
        else $error("control changed without write");
    ctrl_read_a: assert property (@(posedge clock_i) disable iff (rst_i)
        (sfr_addr_i == `DCC_ADDR_CMP1_CTRL) |-> sfr_rdata_o[3:0] == ctrl1_q[3:0])
        else $error("hysteresis read wrong");

    // interrupt requests
    irq_rise_a: assert property (@(posedge clock_i) disable iff (rst_i)
        (rise_q && mode1_q.rise_irq_en) |-> cmp1_irq_o)
        else $error("rise interrupt request missing");
    irq_none_a: assert property (@(posedge clock_i) disable iff (rst_i)
        ((!rise_q || !mode1_q.rise_irq_en) && (!fall_q || !mode1_q.fall_irq_en)) |-> !cmp1_irq_o)
        else $error("spurious interrupt request");
    irq0_rise_a: assert property (@(posedge clock_i) disable iff (rst_i)
        (cmp0_rise_flag_i && mode0_q.rise_irq_en) |-> cmp0_irq_o)
        else $error("comparator 0 rise request missing");
    irq0_fall_a: assert property (@(posedge clock_i) disable iff (rst_i)
        (cmp0_fall_flag_i && mode0_q.fall_irq_en) |-> cmp0_irq_o)
        else $error("comparator 0 fall request missing");
    irq0_none_a: assert property (@(posedge clock_i) disable iff (rst_i)
        (!mode0_q.rise_irq_en && !mode0_q.fall_irq_en) |-> !cmp0_irq_o)
        else $error("comparator 0 request while masked");

    // edge flags
    rise_clear_a: assert property (@(posedge clock_i) disable iff (rst_i)
        rise_clear_s |=> !rise_q)
        else $error("rise flag not cleared");
    fall_clear_a: assert property (@(posedge clock_i) disable iff (rst_i)
        fall_clear_s |=> !fall_q)
        else $error("fall flag not cleared");
    rise_write_a: assert property (@(posedge clock_i) disable iff (rst_i)
        (wr_ctrl && sfr_wdata_i[`DCC_BIT_RISE]) |=> rise_q)
        else $error("rise flag write lost");
    fall_write_a: assert property (@(posedge clock_i) disable iff (rst_i)
        (wr_ctrl && sfr_wdata_i[`DCC_BIT_FALL]) |=> fall_q)
        else $error("fall flag write lost");
    fall_hold_a: assert property (@(posedge clock_i) disable iff (rst_i)
        (fall_q && !wr_ctrl) |=> fall_q)
        else $error("fall flag dropped without clear");
    fall_seq_a: assert property (@(posedge clock_i) disable iff (rst_i)
        fall_seen_s |-> fall_q)
        else $error("falling edge sequence not flagged");

    // synchroniser depth and disabled input
    sync_rise_a: assert property (@(posedge clock_i) disable iff (rst_i)
        $rose(out_q) |-> $past(cmp1_raw_i && ctrl1_q.enable, SYNC_STAGES + 1))
        else $error("output rose without synchronised input");
    sync_fall_a: assert property (@(posedge clock_i) disable iff (rst_i)
        $fell(out_q) |-> !$past(cmp1_raw_i && ctrl1_q.enable, SYNC_STAGES + 1))
        else $error("output fell without synchronised input");
    dis_sync_a: assert property (@(posedge clock_i) disable iff (rst_i)
        !ctrl1_q.enable |=> !sync_q[0])
        else $error("disabled input reached synchroniser");
endmodule

//--- tb/dcc_cmp_model.sv
// behavioural comparator 1 core with mode-dependent response time
`timescale 1ns/100ps
module dcc_cmp_model (
    // input relation and settings from the register block
    input  wire logic               pos_gt_neg_i,
    input  wire dcc_pkg::dcc_ctrl_t ctrl_i,
    input  wire dcc_pkg::dcc_mode_t mode_i,
    // raw comparator output
    output logic                    raw_o
);
    int dly_ns;
    always_comb
    begin
        case (mode_i.speed_mode)
            2'h0:    dly_ns = 100;
            2'h1:    dly_ns = 175;
            2'h2:    dly_ns = 320;
            default: dly_ns = 1050;
        endcase
    end
    initial raw_o = 1'b0;
    // switching off drops the output at once, no response delay
    always @(pos_gt_neg_i or ctrl_i.enable)
    begin
        if (!ctrl_i.enable)
            raw_o <= 1'b0;
        else
            raw_o <= #(dly_ns) pos_gt_neg_i;
    end
endmodule

//--- tb/testbench.sv
// self-checking bench for the comparator control registers
`timescale 1ns/100ps
`include "dcc_cfg.svh"
module testbench;
    localparam logic [7:0] CT = `DCC_ADDR_CMP1_CTRL;
    localparam logic [7:0] M1 = `DCC_ADDR_CMP1_MODE;
    localparam logic [7:0] M0 = `DCC_ADDR_CMP0_MODE;
    localparam logic [7:0] S1 = `DCC_ADDR_CMP1_INSEL;
    localparam logic [7:0] S0 = `DCC_ADDR_CMP0_INSEL;
    logic                clock_i = 1'b0;
    logic                rst_i   = 1'b1;
    logic [7:0]          addr    = 8'h00;
    logic [7:0]          wdata   = 8'h00;
    logic                we      = 1'b0;
    logic                pos_gt  = 1'b0;
    logic                f0_rise = 1'b0;
    logic                f0_fall = 1'b0;
    logic [7:0]          rdata;
    logic                raw;
    logic [1:0]          k;
    dcc_pkg::dcc_insel_t insel0, insel1;
    dcc_pkg::dcc_mode_t  mode0, mode1;
    dcc_pkg::dcc_ctrl_t  ctrl;
    logic                irq0, irq1;
    int                  n_mismatch = 0;
    int                  checks     = 0;
    int                  cycles     = 0;
    always #5 clock_i = ~clock_i;
    dcc_regs dut_u (.clock_i(clock_i), .rst_i(rst_i), .sfr_addr_i(addr), .sfr_wdata_i(wdata),
        .sfr_we_i(we), .sfr_rdata_o(rdata), .cmp1_raw_i(raw), .cmp0_rise_flag_i(f0_rise),
        .cmp0_fall_flag_i(f0_fall), .cmp0_insel_o(insel0), .cmp1_insel_o(insel1),
        .cmp0_mode_o(mode0), .cmp1_mode_o(mode1), .cmp1_ctrl_o(ctrl),
        .cmp0_irq_o(irq0), .cmp1_irq_o(irq1));
    dcc_cmp_model model_u (.pos_gt_neg_i(pos_gt), .ctrl_i(ctrl), .mode_i(mode1), .raw_o(raw));
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock_i);
        #1;
        addr = a;
        wdata = d;
        we = 1'b1;
        @(posedge clock_i);
        #1;
        we = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input string n);
        @(posedge clock_i);
        #1;
        addr = a;
        #1;
        chk(n, e, rdata);
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    always @(posedge clock_i)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            n_mismatch++;
            give_verdict();
        end
    end
    initial
    begin
        repeat (20) @(posedge clock_i);
        #1;
        rst_i = 1'b0;
        rd(CT, 8'h00, "ctrl");
        rd(M1, 8'h02, "mode1");
        rd(M0, 8'h02, "mode0");
        rd(S1, 8'hFF, "insel1");
        rd(S0, 8'hFF, "insel0");
        $display("test reset done");
        for (int c = 0; c < 4; c++)
        begin
            k = c[1:0];
            wr(S0, {2'h1, k, 2'h2, k});
            rd(S0, {2'h3, k, 2'h3, k}, "insel0");
            chk("insel0 out", {4'h0, k, k}, {4'h0, insel0});
            wr(S1, {2'h2, k, 2'h1, ~k});
            chk("insel1 out", {4'h0, k, ~k}, {4'h0, insel1});
            wr(M1, {2'h3, k, 2'h3, k});
            rd(M1, {2'h0, k, 2'h0, k}, "mode1");
            chk("mode1 out", {4'h0, k, k}, {4'h0, mode1});
            wr(M0, {2'h2, ~k, 2'h1, k});
            chk("mode0 out", {4'h0, ~k, k}, {4'h0, mode0});
            wr(CT, {4'h4, k, ~k});
            rd(CT, {4'h0, k, ~k}, "ctrl");
            chk("ctrl out", {3'h0, 1'b0, k, ~k}, {3'h0, ctrl});
        end
        $display("test fields done");
        wr(M1, 8'h20);
        wr(CT, 8'h80);
        wr(CT, 8'h80);
        pos_gt = 1'b1;
        repeat (20) @(posedge clock_i);
        rd(CT, 8'hE0, "rise");
        chk("irq1 rise", 8'h01, {7'h0, irq1});
        wr(CT, 8'h80);
        rd(CT, 8'hC0, "rise clear");
        chk("irq1 clear", 8'h00, {7'h0, irq1});
        wr(M1, 8'h10);
        pos_gt = 1'b0;
        repeat (20) @(posedge clock_i);
        rd(CT, 8'h90, "fall");
        chk("irq1 fall", 8'h01, {7'h0, irq1});
        wr(CT, 8'h80);
        pos_gt = 1'b1;
        repeat (20) @(posedge clock_i);
        wr(CT, 8'h00);
        repeat (20) @(posedge clock_i);
        rd(CT, 8'h10, "disable");
        $display("test edges done");
        wr(M0, 8'h20);
        f0_rise = 1'b1;
        #1;
        chk("irq0 rise", 8'h01, {7'h0, irq0});
        wr(M0, 8'h10);
        chk("irq0 masked", 8'h00, {7'h0, irq0});
        f0_fall = 1'b1;
        #1;
        chk("irq0 fall", 8'h01, {7'h0, irq0});
        wr(8'h9B, 8'hFF);
        rd(8'h9B, 8'h00, "unmapped");
        rd(CT, 8'h10, "ctrl kept");
        $display("test irq and map done");
        give_verdict();
    end
endmodule
